// *** burst_addr_seq.sv ***
// two-bit burst address sequencer, linear or interleaved
`timescale 1ns/1ps
module burst_addr_seq
    import sram_core_pkg::*;
(
    // sequence inputs
    input wire logic i_order,
    input wire logic [BEAT_W-1:0] i_start,
    input wire logic [BEAT_W-1:0] i_beat,
    // sequence output
    output logic [BEAT_W-1:0] o_low
);

    logic [BEAT_W-1:0] linear_low;
    logic [BEAT_W-1:0] interleaved_low;

    // two-bit sum wraps inside the four-word group
    assign linear_low = BEAT_W'(i_start + i_beat);
    assign interleaved_low = i_start ^ i_beat;
    assign o_low = (i_order == ORDER_INTERLEAVED) ? interleaved_low : linear_low;

endmodule // burst_addr_seq

// *** flow_through_burst_sram_core.sv ***
// flow-through burst sram core: burst control, byte writes, output control, sleep
`timescale 1ns/1ps
module flow_through_burst_sram_core
    import sram_core_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // synchronous control from the memory controller
    input wire logic i_clock_qualifier_n,
    input wire logic i_chip_sel_first_n,
    input wire logic i_chip_sel_second,
    input wire logic i_chip_sel_third_n,
    input wire logic i_advance_load,
    input wire logic i_write_n,
    input wire logic [LANES-1:0] i_byte_lane_write_n,
    input wire logic [ADDR_W-1:0] i_addr,
    // output enable and sleep, both asynchronous at the pins
    input wire logic i_output_enable_n,
    input wire logic i_sleep_request,
    // burst order strap
    input wire logic i_burst_order,
    // data and parity bus, split into in, out and enable
    input wire logic [DATA_W-1:0] i_data_io,
    output logic [DATA_W-1:0] o_data_io,
    output logic o_data_io_oe,
    // status
    output logic o_sleeping
);

    // reset release
    logic rst_meta_reg;
    logic rst_sync_n_reg;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_n_reg <= rst_meta_reg;
        end
    end

    // sleep request synchroniser, three stages
    logic sleep_s1_reg;
    logic sleep_s2_reg;
    logic sleep_s3_reg;
    logic sleep_level_reg;

    always_ff @(posedge i_mclk or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            sleep_s1_reg <= 1'b0;
            sleep_s2_reg <= 1'b0;
            sleep_s3_reg <= 1'b0;
            sleep_level_reg <= 1'b0;
        end else begin
            sleep_s1_reg <= i_sleep_request;
            sleep_s2_reg <= sleep_s1_reg;
            sleep_s3_reg <= sleep_s2_reg;
            // a change counts only once the last two stages agree
            if (sleep_s2_reg == sleep_s3_reg) begin
                sleep_level_reg <= sleep_s3_reg;
            end
        end
    end

    // strap passes three stages like the sleep request; unreset, so they settle while reset is held
    logic strap_s1_reg;
    logic strap_s2_reg;
    logic strap_s3_reg;

    always_ff @(posedge i_mclk) begin
        strap_s1_reg <= i_burst_order;
        strap_s2_reg <= strap_s1_reg;
        strap_s3_reg <= strap_s2_reg;
    end

    // strap read once after reset release; later changes are ignored until the next reset
    logic order_reg;
    logic order_caught_reg;

    always_ff @(posedge i_mclk or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            order_reg <= ORDER_LINEAR;
            order_caught_reg <= 1'b0;
        end else if (!order_caught_reg && (strap_s2_reg == strap_s3_reg)) begin
            order_reg <= strap_s3_reg;
            order_caught_reg <= 1'b1;
        end
    end

    // sleep sequencer
    sleep_state_t sleep_state_reg;
    sleep_state_t sleep_state_next;
    logic [1:0] sleep_cnt_reg;
    logic [1:0] sleep_cnt_next;
    logic awake;

    // counter step shared by entry and exit
    function automatic logic [1:0] cnt_step(input logic [1:0] cnt);
        return 2'(cnt + COUNT_ONE);
    endfunction

    // sleep runs without the clock qualifier: the request is asynchronous
    always_comb begin
        sleep_state_next = sleep_state_reg;
        sleep_cnt_next = sleep_cnt_reg;
        case (sleep_state_reg)
            SLP_AWAKE: begin
                if (sleep_level_reg) begin
                    sleep_state_next = SLP_ENTERING;
                    sleep_cnt_next = COUNT_ZERO;
                end
            end
            SLP_ENTERING: begin
                if (sleep_cnt_reg == SLEEP_ENTRY_LAST) begin
                    sleep_state_next = SLP_ASLEEP;
                end else begin
                    sleep_cnt_next = cnt_step(sleep_cnt_reg);
                end
            end
            SLP_ASLEEP: begin
                if (!sleep_level_reg) begin
                    sleep_state_next = SLP_LEAVING;
                    sleep_cnt_next = COUNT_ZERO;
                end
            end
            SLP_LEAVING: begin
                if (sleep_level_reg) begin
                    sleep_state_next = SLP_ASLEEP;
                end else if (sleep_cnt_reg == SLEEP_EXIT_LAST) begin
                    sleep_state_next = SLP_AWAKE;
                end else begin
                    sleep_cnt_next = cnt_step(sleep_cnt_reg);
                end
            end
            default: begin
                sleep_state_next = SLP_AWAKE;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            sleep_state_reg <= SLP_AWAKE;
            sleep_cnt_reg <= COUNT_ZERO;
        end else begin
            sleep_state_reg <= sleep_state_next;
            sleep_cnt_reg <= sleep_cnt_next;
        end
    end

    // operations stop as soon as entry begins and resume only once fully awake
    assign awake = (sleep_state_reg == SLP_AWAKE) && !sleep_level_reg;

    // request decode
    bus_req_t req;
    logic edge_taken;
    logic sel_all;
    logic load;

    assign req = '{
        chip_sel_first_n: i_chip_sel_first_n,
        chip_sel_second: i_chip_sel_second,
        chip_sel_third_n: i_chip_sel_third_n,
        advance_load: i_advance_load,
        write_n: i_write_n,
        byte_lane_write_n: i_byte_lane_write_n,
        addr: i_addr
    };

    // a masked or sleeping edge changes no burst state; a sleeping edge also drops any pending write
    assign edge_taken = !i_clock_qualifier_n && awake;
    assign sel_all = !req.chip_sel_first_n && req.chip_sel_second && !req.chip_sel_third_n;
    assign load = !req.advance_load;

    // burst state
    op_t op_reg;
    logic [ADDR_W-1:0] base_addr_reg;
    logic [BEAT_W-1:0] beat_reg;
    wr_pend_t wr_pend_reg;

    op_t load_op;
    op_t cur_op;
    logic [LANES-1:0] lanes_sel;
    logic [BEAT_W-1:0] next_beat;
    logic [BEAT_W-1:0] beat_low;
    logic [ADDR_W-1:0] burst_addr;
    logic [ADDR_W-1:0] cur_addr;

    // write strobe only matters at a load; an advance keeps the loaded direction
    assign load_op = !sel_all ? OP_DESELECT : (!req.write_n ? OP_WRITE : OP_READ);
    assign next_beat = BEAT_W'(beat_reg + BEAT_STEP);
    // a write load with no lanes still fixes the burst direction as write
    assign cur_op = load ? load_op : op_reg;
    // lanes are active low and sampled fresh on every beat
    assign lanes_sel = ~req.byte_lane_write_n;

    burst_addr_seq u_burst_addr_seq (
        .i_order(order_reg),
        .i_start(base_addr_reg[BEAT_W-1:0]),
        .i_beat(next_beat),
        .o_low(beat_low)
    );

    // upper bits stay as loaded, only the low pair follows the sequence
    assign burst_addr = {base_addr_reg[ADDR_W-1:BEAT_W], beat_low};
    assign cur_addr = load ? req.addr : burst_addr;

    always_ff @(posedge i_mclk or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            op_reg <= OP_DESELECT;
            base_addr_reg <= ADDR_RESET;
            beat_reg <= BEAT_RESET;
        end else if (edge_taken) begin
            op_reg <= cur_op;
            if (load) begin
                base_addr_reg <= req.addr;
                beat_reg <= BEAT_RESET;
            end else begin
                beat_reg <= next_beat;
            end
        end
    end

    // a write latches address and lanes now, data at the next taken edge
    always_ff @(posedge i_mclk or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            wr_pend_reg <= '0;
        end else if (!awake) begin
            wr_pend_reg.valid <= 1'b0;
        end else if (edge_taken) begin
            wr_pend_reg.valid <= (cur_op == OP_WRITE);
            wr_pend_reg.lanes <= lanes_sel;
            wr_pend_reg.addr <= cur_addr;
        end
    end

    // memory array
    logic [DATA_W-1:0] mem [0:MEM_WORDS-1];
    logic wr_commit;
    logic [DATA_W-1:0] wr_word;
    logic [DATA_W-1:0] rd_raw;
    logic [DATA_W-1:0] rd_word;
    logic rd_hits_wr;

    assign wr_commit = edge_taken && wr_pend_reg.valid && (wr_pend_reg.lanes != LANES_NONE);
    assign wr_word = merge_lanes(mem[wr_pend_reg.addr], i_data_io, wr_pend_reg.lanes);
    assign rd_raw = mem[cur_addr];
    // read of the word being written this edge sees the new bytes
    assign rd_hits_wr = wr_pend_reg.valid && (wr_pend_reg.addr == cur_addr);
    assign rd_word = rd_hits_wr ? merge_lanes(rd_raw, i_data_io, wr_pend_reg.lanes) : rd_raw;

    // no reset on the array: contents are undefined at power-up anyway
    always_ff @(posedge i_mclk) begin
        if (wr_commit) begin
            mem[wr_pend_reg.addr] <= wr_word;
        end
    end

    // read data and output drive
    logic read_cycle_reg;
    logic read_taken;
    logic read_now;
    logic oe_next;
    logic asleep_now;
    logic [DATA_W-1:0] dout_reg;
    logic dout_oe_reg;
    logic sleeping_reg;

    assign read_taken = edge_taken && (cur_op == OP_READ);
    // a stalled edge keeps the read cycle, but only while awake
    assign read_now = edge_taken ? (cur_op == OP_READ) : (read_cycle_reg && awake);
    // limitation: output enable acts one edge late, not truly asynchronous
    assign oe_next = read_now && !i_output_enable_n;
    assign asleep_now = (sleep_state_reg == SLP_ASLEEP);

    always_ff @(posedge i_mclk or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            read_cycle_reg <= 1'b0;
        end else begin
            read_cycle_reg <= read_now;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            dout_reg <= DATA_RESET;
        end else if (read_taken) begin
            dout_reg <= rd_word;
        end
    end

    // enable follows output enable sampled each edge, even while the clock is masked
    always_ff @(posedge i_mclk or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            dout_oe_reg <= 1'b0;
        end else begin
            dout_oe_reg <= oe_next;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            sleeping_reg <= 1'b0;
        end else begin
            sleeping_reg <= asleep_now;
        end
    end

    assign o_data_io = dout_reg;
    assign o_data_io_oe = dout_oe_reg;
    assign o_sleeping = sleeping_reg;

endmodule // flow_through_burst_sram_core

// *** flow_through_burst_sram_core_tb.sv ***
// self-checking testbench for the flow-through burst sram core
`timescale 1ns/1ps
module flow_through_burst_sram_core_tb;
    import sram_core_pkg::*;
    localparam logic [2:0] ON = 3'b010;
    localparam logic [2:0] OFF = 3'b101;
    localparam logic [1:0] BOTH = 2'h0;
    logic i_mclk, i_rst_n, order, qual_n, oe_n, sleep, rd_oe, sleeping;
    bus_req_t req;
    logic [DATA_W-1:0] ctl_data, rd_data, bus;
    logic [DATA_W-1:0] mem [int];
    int bad_count, tests_run;
    // device drives the shared bus only while its enable is high
    assign bus = rd_oe ? rd_data : ctl_data;
    flow_through_burst_sram_core u_dut (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_clock_qualifier_n(qual_n),
        .i_chip_sel_first_n(req.chip_sel_first_n),
        .i_chip_sel_second(req.chip_sel_second),
        .i_chip_sel_third_n(req.chip_sel_third_n),
        .i_advance_load(req.advance_load),
        .i_write_n(req.write_n),
        .i_byte_lane_write_n(req.byte_lane_write_n),
        .i_addr(req.addr),
        .i_output_enable_n(oe_n),
        .i_sleep_request(sleep),
        .i_burst_order(order),
        .i_data_io(bus),
        .o_data_io(rd_data),
        .o_data_io_oe(rd_oe),
        .o_sleeping(sleeping)
    );
    sram_ctl_model u_ctl (.i_mclk(i_mclk), .o_req(req), .o_qual_n(qual_n), .o_oe_n(oe_n), .o_sleep(sleep),
                          .o_data(ctl_data));
    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end
    task automatic chk_d(input string what, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk_b(input string what, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    function automatic logic [ADDR_W-1:0] bur(input logic [ADDR_W-1:0] a, input logic [1:0] k);
        return {a[ADDR_W-1:2], order ? a[1:0] ^ k : a[1:0] + k};
    endfunction
    task automatic mem_put(input logic [ADDR_W-1:0] a, input logic [1:0] ln_n, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] e;
        e = mem.exists(a) ? mem[a] : 'x;
        if (!ln_n[0]) e[8:0] = d[8:0];
        if (!ln_n[1]) e[17:9] = d[17:9];
        mem[a] = e;
    endtask
    task automatic idle;
        u_ctl.beat(OFF, 1'b0, 1'b1, BOTH, '0, 1'b0, '0);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [1:0] ln_n, input logic [DATA_W-1:0] d);
        u_ctl.beat(ON, 1'b0, 1'b0, ln_n, a, 1'b0, '0);
        chk_b("write load oe", 1'b0, rd_oe);
        u_ctl.beat(OFF, 1'b0, 1'b1, BOTH, a, 1'b1, d);
        mem_put(a, ln_n, d);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a);
        u_ctl.beat(ON, 1'b0, 1'b1, BOTH, a, 1'b0, '0);
        chk_d("read data", mem[a], rd_data);
        chk_b("read oe", 1'b1, rd_oe);
    endtask
    task automatic do_reset(input logic o);
        i_rst_n = 1'b0;
        order = o;
        repeat (6) @(posedge i_mclk);
        #1 i_rst_n = 1'b1;
        repeat (3) @(posedge i_mclk);
        #1;
        chk_b("power-up oe", 1'b0, rd_oe);
        chk_b("power-up sleep", 1'b0, sleeping);
    endtask
    task automatic t_turnaround;
        u_ctl.beat(ON, 1'b0, 1'b0, BOTH, 21'h00010, 1'b0, '0);
        mem_put(21'h00010, BOTH, 18'h1b2c3);
        u_ctl.beat(ON, 1'b0, 1'b1, BOTH, 21'h00010, 1'b1, 18'h1b2c3);
        chk_d("turnaround read", 18'h1b2c3, rd_data);
        idle();
        chk_b("deselect oe", 1'b0, rd_oe);
    endtask
    task automatic t_lanes;
        for (int i = 0; i < 4; i++) begin
            wr(21'h00020, BOTH, 18'h00000);
            wr(21'h00020, 2'(i), 18'h3ffff);
            rd(21'h00020);
        end
        idle();
    endtask
    task automatic t_burst;
        logic [ADDR_W-1:0] b;
        b = 21'h1a5a4;
        u_ctl.beat(ON, 1'b0, 1'b0, BOTH, b + 21'h1, 1'b0, '0);
        for (int k = 1; k < 5; k++) begin
            mem_put(bur(b + 21'h1, 2'(k - 1)), BOTH, 18'h2a000 + 18'(k));
            u_ctl.beat(OFF, k < 4, 1'b1, BOTH, ~b, 1'b1, 18'h2a000 + 18'(k));
        end
        u_ctl.beat(ON, 1'b0, 1'b1, BOTH, b + 21'h3, 1'b0, '0);
        for (int k = 0; k < 5; k++) begin
            chk_d("burst read", mem[bur(b + 21'h3, 2'(k))], rd_data);
            u_ctl.beat(OFF, k < 4, 1'b0, BOTH, ~b, 1'b0, '0);
        end
        chk_b("burst end oe", 1'b0, rd_oe);
    endtask
    task automatic t_stall;
        rd(21'h1a5a4);
        u_ctl.pins(1'b1, 1'b0, 1'b0);
        repeat (3) begin
            u_ctl.beat(OFF, 1'b0, 1'b0, BOTH, '0, 1'b0, '0);
            chk_d("stalled data", mem[21'h1a5a4], rd_data);
            chk_b("stalled oe", 1'b1, rd_oe);
        end
        u_ctl.pins(1'b0, 1'b0, 1'b0);
        u_ctl.beat(OFF, 1'b1, 1'b0, BOTH, '0, 1'b0, '0);
        chk_d("advance after stall", mem[bur(21'h1a5a4, 2'h1)], rd_data);
        idle();
    endtask
    task automatic t_deselect;
        for (int i = 0; i < 3; i++) begin
            rd(21'h00010);
            u_ctl.beat(ON ^ 3'(3'b100 >> i), 1'b0, 1'b1, BOTH, 21'h00010, 1'b0, '0);
            chk_b("deselect oe", 1'b0, rd_oe);
            u_ctl.beat(ON, 1'b1, 1'b1, BOTH, 21'h00010, 1'b0, '0);
            chk_b("deselect burst oe", 1'b0, rd_oe);
        end
        u_ctl.pins(1'b0, 1'b1, 1'b0);
        u_ctl.beat(ON, 1'b0, 1'b1, BOTH, 21'h00010, 1'b0, '0);
        chk_b("oe high read", 1'b0, rd_oe);
        u_ctl.pins(1'b0, 1'b0, 1'b0);
        idle();
    endtask
    task automatic t_sleep;
        int n;
        wr(21'h00030, BOTH, 18'h15a5a);
        u_ctl.pins(1'b0, 1'b0, 1'b1);
        for (n = 0; sleeping !== 1'b1 && n < 20; n++) idle();
        chk_b("asleep", 1'b1, sleeping);
        u_ctl.pins(1'b0, 1'b0, 1'b0);
        for (n = 0; sleeping !== 1'b0 && n < 20; n++) idle();
        chk_b("awake", 1'b0, sleeping);
        repeat (4) idle();
        rd(21'h00030);
        idle();
    endtask
    initial begin
        repeat (3000) @(posedge i_mclk);
        bad_count++;
        $display("BAD watchdog expired");
        report_and_stop();
    end
    initial begin
        bad_count = 0;
        tests_run = 0;
        // let every process reach its event control before reset falls
        #1;
        do_reset(ORDER_LINEAR);
        t_turnaround();
        t_lanes();
        t_burst();
        t_stall();
        t_deselect();
        do_reset(ORDER_INTERLEAVED);
        t_burst();
        t_sleep();
        report_and_stop();
    end
endmodule // flow_through_burst_sram_core_tb

// *** sram_core_checker_assertions.sv ***
// port-level assertions for the flow-through burst sram core
`timescale 1ns/1ps
module sram_core_checker
    import sram_core_pkg::*;
(
    // watched ports
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_clock_qualifier_n,
    input wire logic i_chip_sel_first_n,
    input wire logic i_chip_sel_second,
    input wire logic i_chip_sel_third_n,
    input wire logic i_advance_load,
    input wire logic i_write_n,
    input wire logic i_output_enable_n,
    input wire logic i_sleep_request,
    input wire logic [DATA_W-1:0] o_data_io,
    input wire logic o_data_io_oe,
    input wire logic o_sleeping
);
    wire sel_ok = !i_chip_sel_first_n && i_chip_sel_second && !i_chip_sel_third_n;
    wire load = !i_clock_qualifier_n && !i_advance_load;
    wire adv = !i_clock_qualifier_n && i_advance_load;
    // last loaded kind: 0 deselect, 1 read, 2 write
    logic [1:0] kind_reg;
    logic [1:0] kind_next;
    assign kind_next = !load ? kind_reg : !sel_ok ? 2'h0 : i_write_n ? 2'h1 : 2'h2;
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            kind_reg <= 2'h0;
        end else begin
            kind_reg <= kind_next;
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    a_stall_holds_data: assert property (i_clock_qualifier_n |=> $stable(o_data_io))
        else $error("read data moved on an ignored edge");
    a_deselect_tristate: assert property (load && !sel_ok |=> !o_data_io_oe)
        else $error("outputs driven after a deselect");
    a_write_outputs_off: assert property (load && sel_ok && !i_write_n |=> !o_data_io_oe)
        else $error("outputs driven in a write");
    a_oe_high_off: assert property (i_output_enable_n |=> !o_data_io_oe)
        else $error("outputs driven with output enable high");
    a_read_drives: assert property (load && sel_ok && i_write_n && !i_output_enable_n |=> o_data_io_oe)
        else $error("read load did not drive the bus");
    a_burst_read_kept: assert property (adv && kind_reg == 2'h1 && !i_output_enable_n |=> o_data_io_oe)
        else $error("read burst beat did not drive the bus");
    a_burst_write_kept: assert property (adv && kind_reg == 2'h2 |=> !o_data_io_oe)
        else $error("write burst beat drove the bus");
    a_deselect_burst: assert property (adv && kind_reg == 2'h0 |=> !o_data_io_oe)
        else $error("deselect burst beat drove the bus");
    a_sleep_entry: assert property ($rose(i_sleep_request) |-> !o_sleeping ##[3:10] o_sleeping)
        else $error("sleep not entered in time");
    a_sleep_exit: assert property ($fell(i_sleep_request) |-> ##[3:10] !o_sleeping)
        else $error("sleep not left in time");
    a_reset_quiet: assert property (disable iff (1'b0) !i_rst_n |-> !o_data_io_oe && !o_sleeping)
        else $error("outputs active in reset");
    c_read_burst: cover property (adv && kind_reg == 2'h1 && !i_output_enable_n);
    c_write_load: cover property (load && sel_ok && !i_write_n);
    c_asleep: cover property (o_sleeping);
endmodule // sram_core_checker

bind flow_through_burst_sram_core sram_core_checker u_chk (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_clock_qualifier_n(i_clock_qualifier_n),
    .i_chip_sel_first_n(i_chip_sel_first_n),
    .i_chip_sel_second(i_chip_sel_second),
    .i_chip_sel_third_n(i_chip_sel_third_n),
    .i_advance_load(i_advance_load),
    .i_write_n(i_write_n),
    .i_output_enable_n(i_output_enable_n),
    .i_sleep_request(i_sleep_request),
    .o_data_io(o_data_io),
    .o_data_io_oe(o_data_io_oe),
    .o_sleeping(o_sleeping)
);

// *** sram_core_pkg.sv ***
// shared constants, types and helpers for the flow-through burst sram core
package sram_core_pkg;

    // array geometry
    localparam int ADDR_W = 21;
    localparam int DATA_W = 18;
    localparam int LANE_W = 9;
    localparam int LANES = 2;
    localparam int BEAT_W = 2;
    localparam int MEM_WORDS = 2097152;

    // strap level for the burst order
    localparam logic ORDER_LINEAR = 1'b0;
    localparam logic ORDER_INTERLEAVED = 1'b1;

    // timing: clock rate and documented figures
    localparam int CLK_PERIOD_PS = 100000;
    localparam int CLOCK_TO_DATA_VALID_PS = 6500;
    // longest time rounds down, but never below one cycle
    localparam int CLOCK_TO_DATA_VALID_CYC = (CLOCK_TO_DATA_VALID_PS / CLK_PERIOD_PS) < 1 ? 1 :
        (CLOCK_TO_DATA_VALID_PS / CLK_PERIOD_PS);
    localparam int SLEEP_ENTRY_TCYC = 2;
    localparam int SLEEP_EXIT_TCYC = 2;
    localparam logic [1:0] SLEEP_ENTRY_LAST = 2'(SLEEP_ENTRY_TCYC - 1);
    localparam logic [1:0] SLEEP_EXIT_LAST = 2'(SLEEP_EXIT_TCYC - 1);
    localparam logic [1:0] COUNT_ZERO = 2'h0;
    localparam logic [1:0] COUNT_ONE = 2'h1;

    // reset values
    localparam logic [ADDR_W-1:0] ADDR_RESET = 21'h000000;
    localparam logic [DATA_W-1:0] DATA_RESET = 18'h00000;
    localparam logic [BEAT_W-1:0] BEAT_RESET = 2'h0;
    localparam logic [BEAT_W-1:0] BEAT_STEP = 2'h1;
    localparam logic [LANES-1:0] LANES_NONE = 2'h0;

    // operation held by the burst logic
    typedef enum logic [1:0] {
        OP_DESELECT = 2'b00,
        OP_READ = 2'b01,
        OP_WRITE = 2'b11
    } op_t;

    // sleep sequencing, gray along awake -> entering -> asleep -> leaving
    typedef enum logic [1:0] {
        SLP_AWAKE = 2'b00,
        SLP_ENTERING = 2'b01,
        SLP_ASLEEP = 2'b11,
        SLP_LEAVING = 2'b10
    } sleep_state_t;

    // synchronous control pins sampled at a rising edge
    typedef struct packed {
        logic chip_sel_first_n;
        logic chip_sel_second;
        logic chip_sel_third_n;
        logic advance_load;
        logic write_n;
        logic [LANES-1:0] byte_lane_write_n;
        logic [ADDR_W-1:0] addr;
    } bus_req_t;

    // write waiting for its data beat
    typedef struct packed {
        logic valid;
        logic [LANES-1:0] lanes;
        logic [ADDR_W-1:0] addr;
    } wr_pend_t;

    // replace the selected nine-bit lanes (eight data bits plus parity)
    function automatic logic [DATA_W-1:0] merge_lanes(input logic [DATA_W-1:0] old_word,
                                                      input logic [DATA_W-1:0] new_word,
                                                      input logic [LANES-1:0] lanes);
        logic [DATA_W-1:0] res;
        res = old_word;
        for (int i = 0; i < LANES; i++) begin
            if (lanes[i]) begin
                res[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
            end
        end
        return res;
    endfunction

endpackage

// *** sram_ctl_model.sv ***
// memory controller model driving the core's synchronous bus
`timescale 1ns/1ps
module sram_ctl_model
    import sram_core_pkg::*;
(
    // clock
    input wire logic i_mclk,
    // bus to the core
    output bus_req_t o_req,
    output logic o_qual_n,
    output logic o_oe_n,
    output logic o_sleep,
    output logic [DATA_W-1:0] o_data
);
    initial begin
        o_req = {3'b101, 1'b0, 1'b1, 2'h3, 21'h0};
        o_qual_n = 1'b0;
        o_oe_n = 1'b0;
        o_sleep = 1'b0;
        o_data = '0;
    end
    // one clock of requests; dv/d carry write data for the previous beat
    task automatic beat(input logic [2:0] sel, input logic adv, input logic we_n, input logic [1:0] ln_n,
                        input logic [ADDR_W-1:0] a, input logic dv, input logic [DATA_W-1:0] d);
        o_req = {sel, adv, we_n, ln_n, a};
        // released bus shows a moving pattern so stale data cannot pass
        o_data = dv ? d : ~o_data;
        @(posedge i_mclk);
        #1;
    endtask
    task automatic pins(input logic q, input logic oe, input logic s);
        o_qual_n = q;
        o_oe_n = oe;
        o_sleep = s;
    endtask
endmodule // sram_ctl_model
